// ### rtl/flash_command_security.sv
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module flash_command_security
#(
    parameter int ARRAY_WORDS   = flash_cmd_pkg::ARRAY_WORDS,
    parameter int SETTLE_CYCLES = flash_cmd_pkg::SETTLE_CYCLES
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    input  wire logic        i_special_single_chip,
    input  wire logic        i_debug_active,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    output logic             o_secured,
    output logic             o_op_done_irq,
    output logic             o_buf_free_irq
);
    localparam int AW        = $clog2(ARRAY_WORDS);
    localparam int PW        = AW + 4;
    localparam int BASE_BYTE = flash_cmd_pkg::FLASH_TOP - 2 * ARRAY_WORDS;
    localparam logic [AW-1:0] KEY_IDX = AW'((flash_cmd_pkg::KEY_BASE_ADDR - BASE_BYTE) / 2);
    localparam logic [AW-1:0] SEC_IDX = AW'((flash_cmd_pkg::SEC_BYTE_ADDR - BASE_BYTE) / 2);
    localparam logic [AW-1:0] SECTOR_MASK = ~AW'(flash_cmd_pkg::SECTOR_WORDS - 1);

    typedef enum {SQ_IDLE, SQ_DATA, SQ_CMD} seq_e;
    typedef enum {EX_IDLE, EX_RUN, EX_SETTLE} exec_e;

    logic [15:0]         mem [ARRAY_WORDS];
    logic                dp_wr;
    logic                dp_rd;
    logic                dp_arr;
    logic [7:0]          dp_reg;
    logic [AW-1:0]       dp_idx;
    logic [7:0]          ctrl;
    logic [7:0]          guard;
    logic [7:0]          lock_cfg;
    logic                load_pend;
    logic                buf_free;
    logic                op_done;
    logic                protect_violation_flag;
    logic                blank;
    logic                buf_full;
    flash_cmd_pkg::cmd_s cmd_buf;
    flash_cmd_pkg::cmd_s cur;
    seq_e                seq;
    exec_e               ex_state;
    logic [AW-1:0]       ptr;
    logic [AW:0]         left;
    logic [7:0]          settle;
    logic                all_erased;
    logic                unsec;
    logic [31:0]         rd_val;
    logic                viol;

    wire        accept     = i_hsel && i_htrans[1] && i_hready;
    wire        busy       = (ex_state != EX_IDLE);
    wire        key_acc    = ctrl[flash_cmd_pkg::CT_KEY_ACC];
    wire        arr_rd_now = accept && !i_hwrite && i_haddr[flash_cmd_pkg::ARRAY_SEL_BIT] && !busy;
    wire        rd_done    = dp_rd && !(dp_arr && busy);
    wire        wr_reg     = dp_wr && !dp_arr;
    wire        wr_arr     = dp_wr && dp_arr;
    wire [7:0]  wdat       = i_hwdata[7:0];
    wire        st_wr      = wr_reg && (dp_reg == flash_cmd_pkg::IDX_STATUS);
    wire        launch_req = st_wr && wdat[flash_cmd_pkg::ST_BUF_FREE] && (seq == SQ_CMD);
    wire        launch_ok  = launch_req && !viol;
    wire        launch_bad = launch_req && viol;
    wire        take       = (ex_state == EX_IDLE) && buf_full;
    wire        finish     = (ex_state == EX_SETTLE) && (settle == 8'h00);
    wire [AW:0] key_off    = {1'b0, dp_idx} - {1'b0, KEY_IDX};
    wire        in_key     = (key_off < (AW+1)'(flash_cmd_pkg::KEY_WORDS));
    wire        gate_on    = (lock_cfg[flash_cmd_pkg::LK_GATE_LSB +: 2]
                              == flash_cmd_pkg::GATE_ENABLED);

    // a word falls under the guard when the guard is shut or it sits in an active region
    function automatic logic guarded(input logic [AW-1:0] idx, input logic [7:0] g);
        logic [PW-1:0] lsz;
        logic [PW-1:0] usz;
        logic [PW-1:0] top_dist;
        lsz      = PW'(flash_cmd_pkg::SECTOR_WORDS) << g[flash_cmd_pkg::GD_LSIZE_LSB +: 2];
        usz      = PW'(flash_cmd_pkg::SECTOR_WORDS) << g[flash_cmd_pkg::GD_USIZE_LSB +: 2];
        top_dist = PW'(ARRAY_WORDS - 1) - PW'(idx);
        guarded  = !g[flash_cmd_pkg::GD_OPEN]
                || (!g[flash_cmd_pkg::GD_LOWER_OFF] && (PW'(idx) < lsz))
                || (!g[flash_cmd_pkg::GD_UPPER_OFF] && (top_dist < usz));
    endfunction

    // violation check of the buffered sequence at launch time
    always_comb
    begin
        viol = 1'b0;
        if (cmd_buf.opcode == flash_cmd_pkg::CMD_MASS)
        begin
            viol = !(guard[flash_cmd_pkg::GD_OPEN] && guard[flash_cmd_pkg::GD_UPPER_OFF]
                     && guard[flash_cmd_pkg::GD_LOWER_OFF]);
        end
        else if (cmd_buf.opcode != flash_cmd_pkg::CMD_VERIFY)
        begin
            viol = guarded(cmd_buf.index[AW-1:0], guard);
        end
    end

    // register read mux for the waited read path
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (dp_arr)
        begin
            rd_val[15:0] = key_acc ? 16'h0000 : mem[dp_idx];
        end
        else
        begin
            unique case (dp_reg)
                flash_cmd_pkg::IDX_CTRL:   rd_val[7:0] = ctrl;
                flash_cmd_pkg::IDX_LOCK:   rd_val[7:0] = lock_cfg;
                flash_cmd_pkg::IDX_FTEST:  rd_val[7:0] = 8'h00;
                flash_cmd_pkg::IDX_GUARD:  rd_val[7:0] = guard;
                flash_cmd_pkg::IDX_STATUS: rd_val[7:0] = {buf_free, op_done, protect_violation_flag,
                                                          2'h0, blank, 2'h0};
                flash_cmd_pkg::IDX_OPCODE: rd_val[7:0] = cmd_buf.opcode;
                default:                   rd_val[7:0] = 8'h00;
            endcase
        end
    end

    // ahb address phase capture; writes take effect in their data phase
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            dp_wr  <= 1'b0;
            dp_arr <= 1'b0;
            dp_reg <= 8'h00;
            dp_idx <= '0;
        end
        else
        begin
            dp_wr <= accept && i_hwrite;
            if (accept)
            begin
                dp_arr <= i_haddr[flash_cmd_pkg::ARRAY_SEL_BIT];
                dp_reg <= i_haddr[9:2];
                dp_idx <= i_haddr[AW+1:2];
            end
        end
    end

    // read answer: array at once when idle, registers and busy array after a wait
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            dp_rd       <= 1'b0;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            o_hrdata    <= 32'h0000_0000;
        end
        else
        begin
            o_hresp <= 1'b0;
            if (arr_rd_now)
            begin
                o_hrdata <= {16'h0000, key_acc ? 16'h0000 : mem[i_haddr[AW+1:2]]};
            end
            else if (accept && !i_hwrite)
            begin
                dp_rd       <= 1'b1;
                o_hreadyout <= 1'b0;
            end
            else if (rd_done)
            begin
                // array reads are held off while an operation runs on the array; register reads are not
                dp_rd       <= 1'b0;
                o_hreadyout <= 1'b1;
                o_hrdata    <= rd_val;
            end
        end
    end

    // control and write guard registers; the backdoor path has no write here
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ctrl  <= flash_cmd_pkg::CTRL_RST;
            guard <= flash_cmd_pkg::GUARD_RST;
        end
        else if (wr_reg && dp_reg == flash_cmd_pkg::IDX_CTRL)
        begin
            ctrl <= wdat & flash_cmd_pkg::CTRL_MASK;
        end
        else if (wr_reg && dp_reg == flash_cmd_pkg::IDX_GUARD)
        begin
            guard <= wdat;
        end
    end

    // command write sequence: array write, valid opcode, then launch
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            seq      <= SQ_IDLE;
            cmd_buf  <= '0;
            buf_full <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                buf_full <= 1'b0;
            end
            unique case (seq)
                SQ_IDLE, SQ_DATA:
                begin
                    if (wr_arr && !key_acc && buf_free)
                    begin
                        cmd_buf.index <= 16'(dp_idx);
                        cmd_buf.data  <= i_hwdata[15:0];
                        seq           <= SQ_DATA;
                    end
                    else if (seq == SQ_DATA && wr_reg && dp_reg == flash_cmd_pkg::IDX_OPCODE
                             && (wdat == flash_cmd_pkg::CMD_VERIFY
                                 || wdat == flash_cmd_pkg::CMD_PROGRAM
                                 || wdat == flash_cmd_pkg::CMD_SECTOR
                                 || wdat == flash_cmd_pkg::CMD_MASS))
                    begin
                        cmd_buf.opcode <= wdat;
                        seq            <= SQ_CMD;
                    end
                end
                SQ_CMD:
                begin
                    if (launch_req)
                    begin
                        seq      <= SQ_IDLE;
                        buf_full <= launch_ok;
                    end
                end
            endcase
        end
    end

    // status flags: a written one clears, a hardware set in the same cycle wins
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            buf_free <= 1'b1;
            op_done  <= 1'b1;
            protect_violation_flag    <= 1'b0;
            blank    <= 1'b0;
        end
        else
        begin
            if (st_wr && wdat[flash_cmd_pkg::ST_OP_DONE])
            begin
                op_done <= 1'b0;
            end
            if (st_wr && wdat[flash_cmd_pkg::ST_PROTECT_VIOLATION_FLAG])
            begin
                protect_violation_flag <= 1'b0;
            end
            if ((st_wr && wdat[flash_cmd_pkg::ST_BLANK])
                || (take && cmd_buf.opcode == flash_cmd_pkg::CMD_VERIFY))
            begin
                blank <= 1'b0;
            end
            if (launch_ok)
            begin
                buf_free <= 1'b0;
                op_done  <= 1'b0;
            end
            if (take)
            begin
                buf_free <= 1'b1; // first stage frees while the second runs
            end
            if (launch_bad)
            begin
                protect_violation_flag <= 1'b1;
            end
            if (finish && !buf_full && !launch_ok)
            begin
                op_done <= 1'b1;
            end
            if (finish && cur.opcode == flash_cmd_pkg::CMD_VERIFY && all_erased)
            begin
                blank <= 1'b1;
            end
        end
    end

    // executor walks the target words, one per cycle, then settles
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ex_state   <= EX_IDLE;
            cur        <= '0;
            ptr        <= '0;
            left       <= '0;
            settle     <= 8'h00;
            all_erased <= 1'b1;
        end
        else
        begin
            unique case (ex_state)
                EX_IDLE:
                begin
                    if (take)
                    begin
                        cur        <= cmd_buf;
                        all_erased <= 1'b1;
                        ex_state   <= EX_RUN;
                        if (cmd_buf.opcode == flash_cmd_pkg::CMD_PROGRAM)
                        begin
                            ptr  <= cmd_buf.index[AW-1:0];
                            left <= (AW+1)'(1);
                        end
                        else if (cmd_buf.opcode == flash_cmd_pkg::CMD_SECTOR)
                        begin
                            ptr  <= cmd_buf.index[AW-1:0] & SECTOR_MASK;
                            left <= (AW+1)'(flash_cmd_pkg::SECTOR_WORDS);
                        end
                        else
                        begin
                            ptr  <= '0;
                            left <= (AW+1)'(ARRAY_WORDS);
                        end
                    end
                end
                EX_RUN:
                begin
                    if (cur.opcode == flash_cmd_pkg::CMD_VERIFY
                        && mem[ptr] != flash_cmd_pkg::ERASED_WORD)
                    begin
                        all_erased <= 1'b0;
                    end
                    ptr  <= ptr + AW'(1);
                    left <= left - (AW+1)'(1);
                    if (left == (AW+1)'(1))
                    begin
                        ex_state <= EX_SETTLE;
                        settle   <= 8'(SETTLE_CYCLES - 1);
                    end
                end
                EX_SETTLE:
                begin
                    settle <= settle - 8'h01;
                    if (settle == 8'h00)
                    begin
                        ex_state <= EX_IDLE;
                    end
                end
            endcase
        end
    end

    // array storage; programming can only clear bits, erase sets them
    always_ff @(posedge i_clk)
    begin
        if (ex_state == EX_RUN)
        begin
            if (cur.opcode == flash_cmd_pkg::CMD_PROGRAM)
            begin
                mem[ptr] <= mem[ptr] & cur.data;
            end
            else if (cur.opcode != flash_cmd_pkg::CMD_VERIFY)
            begin
                mem[ptr] <= flash_cmd_pkg::ERASED_WORD;
            end
        end
    end

    // lock config reloads from the options byte after every reset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            lock_cfg  <= flash_cmd_pkg::LOCK_RST;
            load_pend <= 1'b1;
        end
        else
        begin
            load_pend <= 1'b0;
            if (load_pend)
            begin
                lock_cfg <= mem[SEC_IDX][7:0];
            end
            else if (unsec)
            begin
                // only the live copy changes, the stored byte stays as it was
                lock_cfg[flash_cmd_pkg::LK_STATE_LSB +: 2] <= flash_cmd_pkg::STATE_UNLOCKED;
            end
        end
    end

    // backdoor key monitor sees array writes made during key access
    flash_backdoor_key u_backdoor
    (
        .i_clk         (i_clk),
        .i_rst         (i_rst),
        .i_enable      (gate_on && !(i_special_single_chip && i_debug_active)),
        .i_key_access  (key_acc),
        .i_word_wr     (wr_arr),
        .i_in_key_area (in_key),
        .i_word_sel    (key_off[1:0]),
        .i_word        (i_hwdata[15:0]),
        .i_stored      (mem[KEY_IDX + AW'(key_off[1:0])]),
        .o_unsecure    (unsec)
    );

    // registered outputs; irq lines are flag gated by its enable
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_secured      <= 1'b1;
            o_op_done_irq  <= 1'b0;
            o_buf_free_irq <= 1'b0;
        end
        else
        begin
            o_secured      <= (lock_cfg[flash_cmd_pkg::LK_STATE_LSB +: 2]
                               != flash_cmd_pkg::STATE_UNLOCKED);
            o_op_done_irq  <= op_done && ctrl[flash_cmd_pkg::CT_DONE_IE];
            o_buf_free_irq <= buf_free && ctrl[flash_cmd_pkg::CT_BUF_IE];
        end
    end
endmodule
`default_nettype wire

// ### inc/flash_cmd_pkg.sv
package flash_cmd_pkg;
    // array geometry (16-bit words)
    localparam int ARRAY_WORDS   = 1024;
    localparam int SECTOR_WORDS  = 256;
    localparam int KEY_WORDS     = 4;
    localparam int SETTLE_CYCLES = 4;
    localparam int ARRAY_SEL_BIT = 16;
    // flash byte addresses of the configuration field
    localparam int KEY_BASE_ADDR = 32'h0000ff00;
    localparam int SEC_BYTE_ADDR = 32'h0000ff0e;
    localparam int FLASH_TOP     = 32'h00010000;
    // command codes
    localparam logic [7:0] CMD_VERIFY  = 8'h05;
    localparam logic [7:0] CMD_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_SECTOR  = 8'h40;
    localparam logic [7:0] CMD_MASS    = 8'h41;
    // register indexes, byte address is four times the index
    localparam logic [7:0] IDX_CTRL   = 8'h00;
    localparam logic [7:0] IDX_LOCK   = 8'h01;
    localparam logic [7:0] IDX_FTEST  = 8'h02;
    localparam logic [7:0] IDX_GUARD  = 8'h04;
    localparam logic [7:0] IDX_STATUS = 8'h05;
    localparam logic [7:0] IDX_OPCODE = 8'h06;
    // field positions
    localparam int ST_BUF_FREE   = 7;
    localparam int ST_OP_DONE    = 6;
    localparam int ST_PROTECT_VIOLATION_FLAG      = 5;
    localparam int ST_BLANK      = 2;
    localparam int CT_BUF_IE     = 7;
    localparam int CT_DONE_IE    = 6;
    localparam int CT_KEY_ACC    = 5;
    localparam int GD_OPEN       = 7;
    localparam int GD_UPPER_OFF  = 5;
    localparam int GD_USIZE_LSB  = 3;
    localparam int GD_LOWER_OFF  = 2;
    localparam int GD_LSIZE_LSB  = 0;
    localparam int LK_GATE_LSB   = 6;
    localparam int LK_STATE_LSB  = 0;
    // encodings and reset values
    localparam logic [1:0] GATE_ENABLED   = 2'h2;
    localparam logic [1:0] STATE_UNLOCKED = 2'h2;
    localparam logic [7:0] CTRL_MASK      = 8'he0;
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] GUARD_RST      = 8'hff;
    localparam logic [7:0] LOCK_RST       = 8'h01;
    localparam logic [15:0] ERASED_WORD   = 16'hffff;
    localparam logic [15:0] KEY_BAD_LOW   = 16'h0000;
    localparam logic [15:0] KEY_BAD_HIGH  = 16'hffff;

    // one buffered command write sequence
    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] index;
        logic [15:0] data;
    } cmd_s;
endpackage

// ### rtl/flash_backdoor_key.sv
`timescale 1ns/1ns
`default_nettype none
module flash_backdoor_key
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_enable,
    input  wire logic        i_key_access,
    input  wire logic        i_word_wr,
    input  wire logic        i_in_key_area,
    input  wire logic [1:0]  i_word_sel,
    input  wire logic [15:0] i_word,
    input  wire logic [15:0] i_stored,
    output logic             o_unsecure
);
    logic [2:0] count;
    logic       fail;
    logic       acc_q;
    logic       bad_word;

    // a word is bad when out of order, surplus, forbidden or mismatched
    always_comb
    begin
        bad_word = !i_in_key_area
                || (i_word_sel != count[1:0])
                || (count == 3'(flash_cmd_pkg::KEY_WORDS))
                || (i_word == flash_cmd_pkg::KEY_BAD_LOW)
                || (i_word == flash_cmd_pkg::KEY_BAD_HIGH)
                || (i_word != i_stored);
    end

    // sequence monitor; a failure locks it until the next reset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            count      <= 3'h0;
            fail       <= 1'b0;
            acc_q      <= 1'b0;
            o_unsecure <= 1'b0;
        end
        else
        begin
            acc_q      <= i_key_access;
            o_unsecure <= 1'b0;
            if (i_word_wr && i_key_access)
            begin
                if (bad_word)
                begin
                    fail <= 1'b1;
                end
                if (count != 3'(flash_cmd_pkg::KEY_WORDS))
                begin
                    count <= count + 3'h1;
                end
            end
            if (acc_q && !i_key_access)
            begin
                count <= 3'h0;
                // the stored key is only compared, never written
                if (count == 3'(flash_cmd_pkg::KEY_WORDS) && !fail && i_enable)
                begin
                    o_unsecure <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/flash_command_security_chk.sv
`timescale 1ns/1ns
`default_nettype none
module flash_command_security_chk
#(
    parameter int ARRAY_WORDS   = flash_cmd_pkg::ARRAY_WORDS,
    parameter int SETTLE_CYCLES = flash_cmd_pkg::SETTLE_CYCLES
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic        i_hready,
    input  wire logic        i_special_single_chip,
    input  wire logic        i_debug_active,
    input  wire logic        o_hreadyout,
    input  wire logic        o_hresp,
    input  wire logic [31:0] o_hrdata,
    input  wire logic        o_secured,
    input  wire logic        o_op_done_irq,
    input  wire logic        o_buf_free_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // a transfer is taken at this edge
    wire logic rq = i_hsel && i_htrans[1] && i_hready;

    hresp_okay_a: assert property (o_hresp == 1'b0)
        else $error("slave answered with an error");
    reset_state_a: assert property ($fell(i_rst) |-> o_secured && !o_op_done_irq
        && !o_buf_free_irq) else $error("outputs wrong on leaving reset");
    reg_wait_a: assert property (rq && !i_hwrite && !i_haddr[16]
        |=> !o_hreadyout ##1 o_hreadyout) else $error("register read wait wrong");
    write_nowait_a: assert property (rq && i_hwrite |=> o_hreadyout)
        else $error("write stalled");
    ftest_zero_a: assert property (rq && !i_hwrite && i_haddr[16:2] == 15'h2
        |=> ##1 o_hrdata == 32'h0) else $error("test register not zero");
    reg_byte_a: assert property (rq && !i_hwrite && !i_haddr[16]
        |=> ##1 o_hrdata[31:8] == 24'h0) else $error("register upper bits set");
    debug_block_a: assert property ($fell(o_secured)
        |-> !(i_special_single_chip && i_debug_active)) else $error("unlocked in debug");
    relock_reset_a: assert property (disable iff (1'b0) $rose(o_secured) |-> $past(i_rst))
        else $error("relocked without reset");
endmodule
bind flash_command_security flash_command_security_chk #(.ARRAY_WORDS(ARRAY_WORDS),
    .SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.*);
`default_nettype wire

// ### tb/ahb_host.sv
`timescale 1ns/1ns
`default_nettype none
module ahb_host
(
    input  wire logic        i_clk,
    input  wire logic        i_ready,
    input  wire logic [31:0] i_rdata,
    output logic [31:0]      o_addr,
    output logic [1:0]       o_trans,
    output logic             o_write,
    output logic [31:0]      o_wdata
);
    // idle bus at time zero
    initial
    begin
        o_addr = 32'h0;
        o_trans = 2'h0;
        o_write = 1'b0;
        o_wdata = 32'h0;
    end
    // single word transfer; data inverted after so stale data is never trusted
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        o_addr <= a;
        o_write <= w;
        o_trans <= 2'h2;
        do @(posedge i_clk); while (!i_ready);
        o_trans <= 2'h0;
        o_wdata <= d;
        do @(posedge i_clk); while (!i_ready);
        q = i_rdata;
        o_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### tb/flash_command_security_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module flash_command_security_tb_top;
    logic        i_clk;
    logic        i_rst = 1'b1;
    logic        ssc = 1'b0;
    logic        dbg = 1'b0;
    logic        ready;
    logic        sec;
    logic        done_irq;
    logic        free_irq;
    logic [1:0]  trans;
    logic        write;
    logic [31:0] addr, wdata, rdata, q;
    int          bad_count = 0;
    int          checks_done = 0;
    // small array and short settle keep erase runs brief
    flash_command_security #(.ARRAY_WORDS(512), .SETTLE_CYCLES(1)) u_flash_command_security
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_hsel(1'b1), .i_haddr(addr), .i_htrans(trans),
        .i_hwrite(write), .i_hsize(3'h2), .i_hwdata(wdata), .i_hready(ready),
        .i_special_single_chip(ssc), .i_debug_active(dbg), .o_hreadyout(ready),
        .o_hresp(), .o_hrdata(rdata), .o_secured(sec), .o_op_done_irq(done_irq),
        .o_buf_free_irq(free_irq)
    );
    ahb_host u_ahb_host
    (
        .i_clk(i_clk), .i_ready(ready), .i_rdata(rdata), .o_addr(addr),
        .o_trans(trans), .o_write(write), .o_wdata(wdata)
    );
    // free running bus clock
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    function automatic logic [31:0] ra(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction
    function automatic logic [31:0] aa(input int i);
        return 32'h10000 + 32'(i) * 4;
    endfunction
    task automatic check(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, d);
        u_ahb_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a, exp);
        u_ahb_host.xfer(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    // six cycles of reset, then time for the lock byte to load
    task automatic reset();
        i_rst <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    // data, opcode, launch, then poll until done
    task automatic cmd(input int i, input logic [15:0] d, input logic [7:0] op);
        wr(aa(i), {16'h0, d});
        wr(ra(flash_cmd_pkg::IDX_OPCODE), {24'h0, op});
        wr(ra(flash_cmd_pkg::IDX_STATUS), 32'h80);
        q = 32'h0;
        for (int n = 0; n < 300 && !q[6]; n++)
            u_ahb_host.xfer(1'b0, ra(flash_cmd_pkg::IDX_STATUS), 32'h0, q);
        check(q[6], 1'b1);
    endtask
    // backdoor key sequence with the stored key
    task automatic unlock();
        wr(ra(flash_cmd_pkg::IDX_CTRL), 32'h20);
        for (int k = 1; k < 5; k++)
            wr(aa(383 + k), 32'(k * 16'h1111));
        wr(ra(flash_cmd_pkg::IDX_CTRL), 32'h0);
        repeat (5) @(posedge i_clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // register map and interrupt levels
    task automatic test_regs();
        rd(ra(flash_cmd_pkg::IDX_STATUS), 32'hc0);
        wr(ra(flash_cmd_pkg::IDX_FTEST), 32'hff);
        rd(ra(flash_cmd_pkg::IDX_FTEST), 32'h0);
        rd(ra(8'h03), 32'h0);
        wr(ra(flash_cmd_pkg::IDX_CTRL), 32'hc0);
        repeat (2) @(posedge i_clk);
        check(done_irq & free_irq, 1'b1);
    endtask
    // busy array read waits for the erase
    task automatic test_erase();
        wr(aa(0), 32'h0);
        wr(ra(flash_cmd_pkg::IDX_OPCODE), 32'h41);
        wr(ra(flash_cmd_pkg::IDX_STATUS), 32'h80);
        rd(ra(flash_cmd_pkg::IDX_STATUS), 32'h80);
        rd(aa(511), 32'hffff);
        cmd(0, 16'h0, flash_cmd_pkg::CMD_VERIFY);
        rd(ra(flash_cmd_pkg::IDX_STATUS), 32'hc4);
    endtask
    // opcodes, key words, sector erase
    task automatic test_program();
        wr(aa(7), 32'h0);
        wr(ra(flash_cmd_pkg::IDX_OPCODE), 32'h33);
        rd(ra(flash_cmd_pkg::IDX_OPCODE), 32'h05);
        for (int k = 1; k < 5; k++)
            cmd(383 + k, 16'(k * 16'h1111), flash_cmd_pkg::CMD_PROGRAM);
        cmd(391, 16'hff81, flash_cmd_pkg::CMD_PROGRAM);
        rd(aa(385), 32'h2222);
        cmd(9, 16'h1234, flash_cmd_pkg::CMD_PROGRAM);
        cmd(9, 16'h0, flash_cmd_pkg::CMD_SECTOR);
        rd(aa(9), 32'hffff);
    endtask
    // backdoor refused in debug, then taken
    task automatic test_backdoor();
        ssc <= 1'b1;
        dbg <= 1'b1;
        reset();
        unlock();
        check(sec, 1'b1);
        ssc <= 1'b0;
        reset();
        unlock();
        check(sec, 1'b0);
        rd(ra(flash_cmd_pkg::IDX_LOCK), 32'h82);
        rd(aa(384), 32'h1111);
        rd(ra(flash_cmd_pkg::IDX_GUARD), 32'hff);
    endtask
    // guard refusals, then relock on reset
    task automatic test_protect();
        wr(ra(flash_cmd_pkg::IDX_GUARD), 32'hfb);
        cmd(0, 16'h0, flash_cmd_pkg::CMD_MASS);
        rd(ra(flash_cmd_pkg::IDX_STATUS), 32'he0);
        wr(ra(flash_cmd_pkg::IDX_STATUS), 32'h20);
        cmd(9, 16'h0, flash_cmd_pkg::CMD_PROGRAM);
        rd(ra(flash_cmd_pkg::IDX_STATUS), 32'he0);
        wr(ra(flash_cmd_pkg::IDX_STATUS), 32'h20);
        rd(ra(flash_cmd_pkg::IDX_STATUS), 32'hc0);
        rd(aa(9), 32'hffff);
        reset();
        check(sec, 1'b1);
        rd(ra(flash_cmd_pkg::IDX_LOCK), 32'h81);
    endtask
    // registers, erase, program, backdoor and protection in turn
    initial
    begin
        reset();
        test_regs();
        test_erase();
        test_program();
        test_backdoor();
        test_protect();
        test_done();
    end
    // hang guard, far beyond the expected run
    initial
    begin
        #400000;
        bad_count++;
        test_done();
    end
endmodule
`default_nettype wire
